// ===== verification/dcir_cpu_model.sv
// Model of the two processors that own the register port of the router.
// Assumes the router samples its strobes on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
`include "dcir_defines.svh"
module dcir_cpu_model
    import dcir_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register port
    output logic [19:0] regAddr,
    output logic [31:0] regWdata,
    output logic regWr,
    output logic regRd,
    input wire logic [31:0] regRdata
);
    // ====================
    // Bus cycles
    int respDelay = 0;
    initial begin
        regAddr = 20'h00000;
        regWdata = 32'h00000000;
        regWr = 1'h0;
        regRd = 1'h0;
    end
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'h1;
        @(posedge clk);
        regWr <= 1'h0;
        regAddr <= ~a;
        regWdata <= ~d;
    endtask : wr
    task automatic rd(input logic [19:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'h1;
        @(posedge clk);
        regRd <= 1'h0;
        regAddr <= ~a;
        #1;
        d = regRdata;
    endtask : rd
    // ====================
    // Service calls
    function automatic logic [19:0] cpuOfs(input logic c);
        return 20'(c) << `DCIR_CPU_SHIFT;
    endfunction : cpuOfs
    task automatic ack(input logic c, output logic [31:0] v);
        repeat (respDelay) @(posedge clk);
        rd(`DCIR_ACK_OFS + cpuOfs(c), v);
    endtask : ack
    task automatic end_of_service_cmd(input logic c);
        wr(`DCIR_EOI_OFS + cpuOfs(c), 32'h00000000);
    endtask : end_of_service_cmd
    task automatic setTask(input logic c, input logic [3:0] p);
        wr(`DCIR_TASK_OFS + cpuOfs(c), {28'h0000000, p});
    endtask : setTask
    task automatic setMode(input logic tie);
        wr(`DCIR_CFG_OFS, {31'h00000000, tie});
    endtask : setMode
    task automatic cfgSrc(input int s, input logic [3:0] p, input logic [7:0] v,
                          input logic [1:0] dst, input logic en);
        logic [19:0] a;
        logic [31:0] d;
        a = `DCIR_VP_BASE + 20'(s * 32);
        wr(a, 32'h80000000);
        for (int i = 0; i < 20; i++) begin
            rd(a, d);
            if (d[`DCIR_VP_ACT] === 1'h0) break;
        end
        wr(a + 20'(`DCIR_DEST_SUB), {30'h00000000, dst});
        wr(a, {12'h800, p, 8'h00, v});
        if (en) wr(a, {12'h000, p, 8'h00, v});
    endtask : cfgSrc
endmodule : dcir_cpu_model
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the two-processor interrupt router.
// Assumes the processor model drives the register port of the router.
`timescale 1ns/1ps
`default_nettype none
`include "dcir_defines.svh"
module tb_top
    import dcir_pkg::*;
;
    // ====================
    // Signals
    logic clk;
    logic resetn;
    logic [19:0] regAddr;
    logic [31:0] regWdata;
    logic regWr;
    logic regRd;
    logic [31:0] regRdata;
    logic [`DCIR_NEXT-1:0] extIrq;
    logic errIrq;
    logic [3:0] timerEvt;
    logic [1:0] cpuInt;
    logic [1:0] procInit;
    logic [31:0] rdv;
    logic [1:0] m;
    logic [15:0] tieTab [4] = '{16'h2102, 16'h1211, 16'h1101, 16'h1112};
    int fails = 0;
    int samplesChecked = 0;
    dcir_router uut (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .extIrq(extIrq),
        .errIrq(errIrq), .timerEvt(timerEvt), .cpuInt(cpuInt), .procInit(procInit));
    dcir_cpu_model cpuM (.clk(clk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata));
    // ====================
    // Helpers
    task automatic end_sim();
        $display("Compared %0d mismatched %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samplesChecked++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic pins(input logic [1:0] e);
        repeat (14) @(posedge clk);
        #1;
        chk("cpuInt", {30'h0, e}, {30'h0, cpuInt});
    endtask : pins
    task automatic ackChk(input logic c, input logic [7:0] e);
        cpuM.ack(c, rdv);
        chk("vector", {24'h0, e}, rdv);
    endtask : ackChk
    task automatic pulse(input int s);
        @(posedge clk);
        extIrq[s] <= 1'h1;
        repeat (2) @(posedge clk);
        extIrq[s] <= 1'h0;
    endtask : pulse
    // ====================
    // Clock and watchdog
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    initial begin
        #400000;
        $display("[FAIL] watchdog expected finish seen hang");
        fails++;
        end_sim();
    end
    // ====================
    // Tests
    initial begin
        resetn = 1'h0;
        extIrq = 16'h0000;
        errIrq = 1'h0;
        timerEvt = 4'h0;
        repeat (16) @(posedge clk);
        resetn <= 1'h1;
        cpuM.rd(`DCIR_TASK_OFS, rdv);
        chk("task0", 32'h0000000f, rdv);
        cpuM.rd(`DCIR_TASK_OFS + 20'h01000, rdv);
        chk("task1", 32'h0000000f, rdv);
        cpuM.rd(`DCIR_VP_BASE + 20'h00060, rdv);
        chk("source3", 32'h80000000, rdv);
        cpuM.rd(`DCIR_CFG_OFS, rdv);
        chk("mode", 32'h00000002, rdv);
        cpuM.rd(20'h00ffc, rdv);
        chk("unmapped", 32'h00000000, rdv);
        chk("procInit", 32'h00000000, {30'h0, procInit});
        @(posedge clk);
        extIrq[0] <= 1'h1;
        pins(2'h1);
        ackChk(1'h0, 8'hff);
        @(posedge clk);
        extIrq[0] <= 1'h0;
        pins(2'h0);
        cpuM.wr(`DCIR_INIT_OFS, 32'h00000003);
        repeat (2) @(posedge clk);
        #1;
        chk("procInit", 32'h00000003, {30'h0, procInit});
        cpuM.setMode(1'h0);
        cpuM.setTask(1'h0, 4'h0);
        cpuM.setTask(1'h1, 4'h0);
        $display("Test reset and pass-through done");
        cpuM.cfgSrc(1, 4'h5, 8'h41, 2'h1, 1'h0);
        pulse(1);
        pins(2'h0);
        cpuM.rd(`DCIR_VP_BASE + 20'h00020, rdv);
        chk("activity", 32'hc0050041, rdv);
        cpuM.wr(`DCIR_VP_BASE + 20'h00020, 32'h00050041);
        pins(2'h1);
        ackChk(1'h0, 8'h41);
        pins(2'h0);
        ackChk(1'h0, 8'hff);
        cpuM.cfgSrc(2, 4'h5, 8'h42, 2'h1, 1'h1);
        cpuM.cfgSrc(3, 4'h7, 8'h43, 2'h1, 1'h1);
        pulse(2);
        pins(2'h0);
        pulse(3);
        pins(2'h1);
        ackChk(1'h0, 8'h43);
        cpuM.end_of_service_cmd(1'h0);
        pins(2'h0);
        cpuM.end_of_service_cmd(1'h0);
        pins(2'h1);
        ackChk(1'h0, 8'h42);
        cpuM.end_of_service_cmd(1'h0);
        pins(2'h0);
        $display("Test nesting done");
        cpuM.setTask(1'h0, 4'h5);
        pulse(2);
        pins(2'h0);
        cpuM.setTask(1'h0, 4'h4);
        pins(2'h1);
        cpuM.respDelay = 3;
        ackChk(1'h0, 8'h42);
        cpuM.respDelay = 0;
        cpuM.end_of_service_cmd(1'h0);
        $display("Test task priority done");
        cpuM.cfgSrc(4, 4'h6, 8'h44, 2'h3, 1'h1);
        foreach (tieTab[i]) begin
            cpuM.setTask(1'h0, tieTab[i][15:12]);
            cpuM.setTask(1'h1, tieTab[i][11:8]);
            cpuM.setMode(tieTab[i][4]);
            pulse(4);
            pins(tieTab[i][1:0]);
            ackChk(tieTab[i][1], 8'h44);
            pins(2'h0);
            cpuM.end_of_service_cmd(tieTab[i][1]);
        end
        $display("Test shared routing done");
        for (int k = 0; k < 4; k++) begin
            m = (k == 0) ? 2'h1 : (k == 1) ? 2'h2 : 2'h3;
            cpuM.cfgSrc(21 + k, 4'h9, 8'h60 + 8'(k), 2'h0, 1'h1);
            cpuM.wr(`DCIR_IPI_OFS + 20'(k * 16) + (k[0] ? 20'h01000 : 20'h00000), {30'h0, m});
            pins(m);
            if (m[0]) ackChk(1'h0, 8'h60 + 8'(k));
            pins(m & 2'h2);
            if (m[1]) ackChk(1'h1, 8'h60 + 8'(k));
            pins(2'h0);
            if (m[0]) cpuM.end_of_service_cmd(1'h0);
            if (m[1]) cpuM.end_of_service_cmd(1'h1);
        end
        $display("Test dispatch done");
        cpuM.cfgSrc(17, 4'h3, 8'h51, 2'h2, 1'h1);
        @(posedge clk);
        timerEvt <= 4'hf;
        @(posedge clk);
        timerEvt <= 4'h0;
        pins(2'h2);
        ackChk(1'h1, 8'h51);
        cpuM.end_of_service_cmd(1'h1);
        pins(2'h0);
        $display("Test timer done");
        cpuM.cfgSrc(16, 4'h8, 8'h50, 2'h1, 1'h1);
        errIrq <= 1'h1;
        pins(2'h1);
        ackChk(1'h0, 8'h50);
        cpuM.end_of_service_cmd(1'h0);
        pins(2'h0);
        errIrq <= 1'h0;
        resetn <= 1'h0;
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
        cpuM.rd(`DCIR_TASK_OFS + 20'h01000, rdv);
        chk("task1", 32'h0000000f, rdv);
        cpuM.rd(`DCIR_CFG_OFS, rdv);
        chk("mode", 32'h00000002, rdv);
        chk("procInit", 32'h00000000, {30'h0, procInit});
        chk("cpuInt", 32'h00000000, {30'h0, cpuInt});
        $display("Test error source and reset done");
        end_sim();
    end
endmodule : tb_top
`default_nettype wire

// ===== verilog/dcir_defines.svh
// Offsets, field positions, reset values and counts of the interrupt router.
// Assumes it is included by its bare name from the package and the router.
`ifndef DCIR_DEFINES_SVH
`define DCIR_DEFINES_SVH

// ==========================================================
// Source numbering
`define DCIR_NSRC 25
`define DCIR_NEXT 16
`define DCIR_NDIST 17
`define DCIR_NDIR 8
`define DCIR_NTMR 4
`define DCIR_NIPI 4
`define DCIR_NCPU 2
`define DCIR_NPRIO 15

// ==========================================================
// Register offsets
`define DCIR_CPU_SHIFT 12
`define DCIR_ACK_OFS 20'h200a0
`define DCIR_EOI_OFS 20'h200b0
`define DCIR_TASK_OFS 20'h20080
`define DCIR_IPI_OFS 20'h20040
`define DCIR_IPI_STRIDE 20'h00010
`define DCIR_CFG_OFS 20'h01020
`define DCIR_INIT_OFS 20'h01090
`define DCIR_VP_BASE 20'h10000
`define DCIR_DEST_SUB 5'h10

// ==========================================================
// Field positions
`define DCIR_VP_MASK 31
`define DCIR_VP_ACT 30
`define DCIR_VP_SENSE 22
`define DCIR_CFG_TIE 0
`define DCIR_CFG_PASS 1

// ==========================================================
// Reset values
`define DCIR_TASK_RST 4'hf
`define DCIR_PASS_RST 1'b1
`define DCIR_SPURIOUS 8'hff

`endif

// ===== verilog/dcir_pkg.sv
// Types shared by the interrupt router.
// Assumes dcir_defines.svh is on the include path.
`default_nettype none
package dcir_pkg;
`include "dcir_defines.svh"

    // ==========================================================
    // Per-source vector and priority setting
    typedef struct packed {
        logic mask;
        logic sense;
        logic [3:0] prio;
        logic [7:0] vector;
    } dcir_src_cfg_t;

    // ==========================================================
    // Selector output held in the request register
    typedef struct packed {
        logic valid;
        logic [4:0] src;
        logic [3:0] prio;
    } dcir_req_t;

    // ==========================================================
    // In-service bits: one per priority level, one per source
    typedef struct packed {
        logic [`DCIR_NPRIO:1] prio;
        logic [`DCIR_NSRC-1:0] src;
    } dcir_isr_t;

endpackage : dcir_pkg
`default_nettype wire

// ===== verilog/dcir_router.sv
// Delivery core of a two-processor interrupt controller.
// Assumes one clock, a register master with one-cycle strobes, pins on extIrq.
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dcir_defines.svh"

// Summary of operation
// - Each in-service set holds 40 bits.
// - Pin decision uses service, task, destination, request.
// - Distributed pending bit qualified by destination.
// - Edge distributed pending cleared on vector read.
// - Direct sources keep one pending bit each processor.
// - Exclusive external needs priority above both.
// - Shared external goes to lower task processor.
// - Internal sources need priority above both.
// - Equal task priorities resolved by tie bit.
// - Acknowledge address is base plus processor shift.
// - Acknowledge blocks equal or lower priorities.
// - Legacy vector fetched by software, not here.
// - Reset sets task 15, masks, clears state.
// - Pass-through sends external 0 to processor 0.
// - Four shared dispatch registers, two addresses each.
// - Dispatch to own processor self-interrupts.
// - End command clears highest in-service priority.
// - Acknowledge read returns the causing vector.
// - Delivery needs priority above task register.
// - Request register pipelines the combinational selector.
// - Request register holds during acknowledge.
// - Acknowledge sets, end command clears in-service.
// - Mask gates pending; held request appears unmasked.
module dcir_router
    import dcir_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [19:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Interrupt sources
    input wire logic [`DCIR_NEXT-1:0] extIrq,
    input wire logic errIrq,
    input wire logic [`DCIR_NTMR-1:0] timerEvt,
    // Processor side
    output logic [`DCIR_NCPU-1:0] cpuInt,
    output logic [`DCIR_NCPU-1:0] procInit
);

    // ==========================================================
    // Storage
    localparam logic [19:0] VpBase = `DCIR_VP_BASE;
    logic [`DCIR_NEXT-1:0] extMeta_q, extSync_q;
    logic [`DCIR_NDIST-1:0] lvlPrev_q, pendD_q, distClr;
    logic [`DCIR_NDIR-1:0] pendX_q [2];
    logic [`DCIR_NDIR-1:0] evt [2];
    logic [`DCIR_NDIR-1:0] xClr [2];
    dcir_src_cfg_t cfg_q [`DCIR_NSRC];
    logic [1:0] dest_q [`DCIR_NSRC];
    dcir_req_t irr_q [2];
    dcir_req_t sel [2];
    dcir_isr_t isr_q [2];
    logic [3:0] task_q [2];
    logic [3:0] topIsr [2];
    logic [7:0] ackVec [2];
    logic [`DCIR_NSRC-1:0] reqVec [2];
    logic [`DCIR_NSRC-1:0] destCpu [2];
    logic [`DCIR_NSRC-1:0] maskVec, senseVec, actVec;
    logic [`DCIR_NDIST-1:0] lvl;
    logic [1:0] ackRd, eoiWr, taskWr, deliver, ackGood, int_q, init_q;
    logic [`DCIR_NIPI-1:0] ipiWr;
    logic tie_q, pass_q, vpHit, dHit;
    logic [19:0] srcOfs;
    logic [4:0] srcIdx;
    logic [31:0] rdata_q;

    // ==========================================================
    // Decoding
    function automatic logic regAt(input logic [19:0] a, input logic [19:0] base,
                                   input logic cpu);
        regAt = (a == (base | (20'(cpu) << `DCIR_CPU_SHIFT)));
    endfunction : regAt

    function automatic logic [3:0] topPrio(input logic [`DCIR_NPRIO:1] p);
        topPrio = 4'h0;
        for (int i = 1; i <= `DCIR_NPRIO; i++) begin
            if (p[i]) begin
                topPrio = 4'(i);
            end
        end
    endfunction : topPrio

    assign srcOfs = regAddr - VpBase;
    assign srcIdx = srcOfs[9:5];
    assign vpHit = (regAddr[19:10] == VpBase[19:10]) && (srcOfs[4:0] == 5'h00)
                   && (srcIdx < 5'(`DCIR_NSRC));
    assign dHit = (regAddr[19:10] == VpBase[19:10]) && (srcOfs[4:0] == `DCIR_DEST_SUB)
                  && (srcIdx < 5'(`DCIR_NSRC));
    assign lvl = {errIrq, extSync_q};

    genvar g, c;
    generate
        for (g = 0; g < `DCIR_NIPI; g++) begin : gIpi
            localparam logic [19:0] Ofs = `DCIR_IPI_OFS + 20'(g) * `DCIR_IPI_STRIDE;
            assign ipiWr[g] = regWr && (regAt(regAddr, Ofs, 1'b0) || regAt(regAddr, Ofs, 1'b1));
        end
        for (g = 0; g < `DCIR_NSRC; g++) begin : gSrc
            assign destCpu[0][g] = dest_q[g][0];
            assign destCpu[1][g] = dest_q[g][1];
            assign maskVec[g] = cfg_q[g].mask;
            assign senseVec[g] = cfg_q[g].sense;
        end
    endgenerate

    // ==========================================================
    // Pin synchroniser
    always_ff @(posedge clk) begin
        if (!resetn) begin
            extMeta_q <= '0;
            extSync_q <= '0;
            lvlPrev_q <= '0;
        end else begin
            extMeta_q <= extIrq;
            extSync_q <= extMeta_q;
            lvlPrev_q <= lvl;
        end
    end

    // ==========================================================
    // Per-processor selector, router and in-service set
    generate
        for (c = 0; c < `DCIR_NCPU; c++) begin : gCpu
            localparam int O = 1 - c;
            logic pOk, ext, dstO, tieWin, take;
            logic [15:0] setP, clrP;
            logic [`DCIR_NSRC-1:0] setS, clrS;

            assign ackRd[c] = regRd && regAt(regAddr, `DCIR_ACK_OFS, 1'(c));
            assign eoiWr[c] = regWr && regAt(regAddr, `DCIR_EOI_OFS, 1'(c));
            assign taskWr[c] = regWr && regAt(regAddr, `DCIR_TASK_OFS, 1'(c));
            assign topIsr[c] = topPrio(isr_q[c].prio);
            assign evt[c] = {ipiWr & {`DCIR_NIPI{regWdata[c]}},
                             timerEvt & destCpu[c][`DCIR_NSRC-1-`DCIR_NIPI:`DCIR_NDIST]};
            assign reqVec[c] = {pendX_q[c], pendD_q & destCpu[c][`DCIR_NDIST-1:0]}
                               & ~maskVec;

            always_comb begin
                sel[c] = '0;
                for (int s = 0; s < `DCIR_NSRC; s++) begin
                    if (reqVec[c][s] && (!sel[c].valid || cfg_q[s].prio > sel[c].prio)) begin
                        sel[c].valid = 1'b1;
                        sel[c].src = 5'(s);
                        sel[c].prio = cfg_q[s].prio;
                    end
                end
            end

            always_comb begin
                pOk = irr_q[c].valid && (irr_q[c].prio > topIsr[c])
                      && (irr_q[c].prio > task_q[c]);
                ext = irr_q[c].src < 5'(`DCIR_NDIST);
                dstO = ext && destCpu[O][irr_q[c].src];
                tieWin = (task_q[c] < task_q[O]) ||
                         ((task_q[c] == task_q[O]) && (tie_q == 1'(c)));
                if (!ext) begin
                    deliver[c] = pOk;
                end else if (!dstO) begin
                    deliver[c] = pOk;
                end else begin
                    deliver[c] = pOk && !isr_q[O].src[irr_q[c].src] && tieWin;
                end
            end

            assign ackGood[c] = !pass_q && deliver[c];
            assign take = ackRd[c] && ackGood[c];
            assign ackVec[c] = ackGood[c] ? cfg_q[irr_q[c].src].vector : `DCIR_SPURIOUS;
            assign setP = take ? (16'h0001 << irr_q[c].prio) : 16'h0000;
            assign setS = take ? (`DCIR_NSRC'(1) << irr_q[c].src) : '0;
            assign clrP = eoiWr[c] ? (16'h0001 << topIsr[c]) : 16'h0000;

            always_comb begin
                clrS = '0;
                xClr[c] = '0;
                for (int s = 0; s < `DCIR_NSRC; s++) begin
                    if (eoiWr[c] && isr_q[c].src[s] && (cfg_q[s].prio == topIsr[c])) begin
                        clrS[s] = 1'b1;
                    end
                end
                if (take && !ext) begin
                    xClr[c][3'(irr_q[c].src - 5'(`DCIR_NDIST))] = 1'b1;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    irr_q[c] <= '0;
                end else if (!ackRd[c]) begin
                    irr_q[c] <= sel[c];
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    isr_q[c] <= '0;
                end else begin
                    isr_q[c].prio <= (isr_q[c].prio & ~clrP[15:1]) | setP[15:1];
                    isr_q[c].src <= (isr_q[c].src & ~clrS) | setS;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    pendX_q[c] <= '0;
                end else begin
                    pendX_q[c] <= (pendX_q[c] & ~xClr[c]) | evt[c];
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    task_q[c] <= `DCIR_TASK_RST;
                    int_q[c] <= 1'b0;
                end else begin
                    if (taskWr[c]) begin
                        task_q[c] <= regWdata[3:0];
                    end
                    if (pass_q) begin
                        int_q[c] <= (c == 0) ? extSync_q[0] : 1'b0;
                    end else begin
                        int_q[c] <= deliver[c];
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Distributed pending bits
    always_comb begin
        distClr = '0;
        for (int k = 0; k < `DCIR_NCPU; k++) begin
            if (ackRd[k] && ackGood[k] && irr_q[k].src < 5'(`DCIR_NDIST)) begin
                distClr[irr_q[k].src] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pendD_q <= '0;
        end else begin
            for (int s = 0; s < `DCIR_NDIST; s++) begin
                if (senseVec[s]) begin
                    pendD_q[s] <= lvl[s];
                end else if (lvl[s] && !lvlPrev_q[s]) begin
                    pendD_q[s] <= 1'b1;
                end else if (distClr[s]) begin
                    pendD_q[s] <= 1'b0;
                end
            end
        end
    end

    assign actVec = {pendX_q[0] | pendX_q[1], pendD_q} | isr_q[0].src | isr_q[1].src;

    // ==========================================================
    // Configuration registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int s = 0; s < `DCIR_NSRC; s++) begin
                cfg_q[s] <= '{mask: 1'b1, sense: 1'b0, prio: 4'h0, vector: 8'h00};
                dest_q[s] <= 2'h0;
            end
        end else begin
            if (regWr && vpHit) begin
                cfg_q[srcIdx].mask <= regWdata[`DCIR_VP_MASK];
                cfg_q[srcIdx].sense <= regWdata[`DCIR_VP_SENSE];
                cfg_q[srcIdx].prio <= regWdata[19:16];
                cfg_q[srcIdx].vector <= regWdata[7:0];
            end
            if (regWr && dHit) begin
                dest_q[srcIdx] <= regWdata[1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            tie_q <= 1'b0;
            pass_q <= `DCIR_PASS_RST;
            init_q <= 2'h0;
        end else begin
            if (regWr && regAddr == `DCIR_CFG_OFS) begin
                tie_q <= regWdata[`DCIR_CFG_TIE];
                pass_q <= regWdata[`DCIR_CFG_PASS];
            end
            if (regWr && regAddr == `DCIR_INIT_OFS) begin
                init_q <= regWdata[1:0];
            end
        end
    end

    // ==========================================================
    // Read data
    always_ff @(posedge clk) begin
        if (!resetn || !regRd) begin
            rdata_q <= 32'h00000000;
        end else if (ackRd[0]) begin
            rdata_q <= {24'h000000, ackVec[0]};
        end else if (ackRd[1]) begin
            rdata_q <= {24'h000000, ackVec[1]};
        end else if (regAt(regAddr, `DCIR_TASK_OFS, 1'b0)) begin
            rdata_q <= {28'h0000000, task_q[0]};
        end else if (regAt(regAddr, `DCIR_TASK_OFS, 1'b1)) begin
            rdata_q <= {28'h0000000, task_q[1]};
        end else if (vpHit) begin
            rdata_q <= {cfg_q[srcIdx].mask, actVec[srcIdx], 7'h00, cfg_q[srcIdx].sense,
                        2'h0, cfg_q[srcIdx].prio, 8'h00, cfg_q[srcIdx].vector};
        end else if (dHit) begin
            rdata_q <= {30'h00000000, dest_q[srcIdx]};
        end else if (regAddr == `DCIR_CFG_OFS) begin
            rdata_q <= {30'h00000000, pass_q, tie_q};
        end else if (regAddr == `DCIR_INIT_OFS) begin
            rdata_q <= {30'h00000000, init_q};
        end else begin
            rdata_q <= 32'h00000000;
        end
    end

    assign regRdata = rdata_q;
    assign cpuInt = int_q;
    assign procInit = init_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence ackTaken0;
        ackRd[0] && ackGood[0];
    endsequence

    ackHold_a: assert property (ackRd[0] |=> irr_q[0] == $past(irr_q[0]))
        else $error("request register moved during acknowledge");
    irrFollow_a: assert property (!ackRd[1] |=> irr_q[1] == $past(sel[1]))
        else $error("request register did not follow selector");
    passRoute_a: assert property ($past(pass_q) |-> cpuInt[0] == $past(extSync_q[0])
                                  && !cpuInt[1])
        else $error("pass-through routing wrong");
    taskGate_a: assert property (cpuInt[0] && !$past(pass_q) |->
                                 $past(irr_q[0].prio) > $past(task_q[0]))
        else $error("delivered at or below task priority");
    serviceBlock_a: assert property (cpuInt[1] && !$past(pass_q) |->
                                     $past(irr_q[1].prio) > $past(topIsr[1]))
        else $error("delivered at or below in-service priority");
    ackVector_a: assert property (ackTaken0 |=> regRdata[7:0] == $past(ackVec[0])
                                  && regRdata[31:8] == 24'h000000)
        else $error("acknowledge returned wrong vector");
    ackSets_a: assert property (ackTaken0 |=> isr_q[0].prio[$past(irr_q[0].prio)])
        else $error("acknowledge did not set in-service priority");
    eoiClear_a: assert property (eoiWr[0] && topIsr[0] != 4'h0 |=>
                                 !isr_q[0].prio[$past(topIsr[0])])
        else $error("end command left top priority in service");
    selfIpi_a: assert property (ipiWr[0] && regWdata[0] |=> pendX_q[0][0 + `DCIR_NTMR])
        else $error("self dispatch not pending");
    multiIpi_a: assert property (ipiWr[1] && regWdata[1:0] == 2'h3 |=>
                                 pendX_q[0][1 + `DCIR_NTMR] && pendX_q[1][1 + `DCIR_NTMR])
        else $error("multicast dispatch not pending on both");
    tieMode_a: assert property (deliver[0] && deliver[1] |-> irr_q[0].src != irr_q[1].src
                                || irr_q[0].src >= 5'(`DCIR_NDIST))
        else $error("distributed source delivered to both");

endmodule : dcir_router
`default_nettype wire
